// File: design/sqc_regs.vh
// Register map, field positions, reset values and timing of the switch global QoS control bank.
// Assumes an 8-bit register port with 16-bit byte addresses and a 40 MHz system clock.
`ifndef SQC_REGS_VH
`define SQC_REGS_VH

// ****************************************
// Offsets
// ****************************************
`define SQC_ADDR_W          16
`define SQC_STORM_HIGH      16'h0332
`define SQC_STORM_LOW       16'h0333
`define SQC_PAUSE_FWD       16'h0334
`define SQC_RATE_CFG        16'h0335
`define SQC_CNT_CTRL        16'h0336
`define SQC_TAG_MAP_0       16'h0338
`define SQC_TAG_MAP_1       16'h0339
`define SQC_TAG_MAP_2       16'h033a
`define SQC_TAG_MAP_3       16'h033b
`define SQC_DSCP_EN         16'h033e
`define SQC_DSCP_MAP_FIRST  16'h0340
`define SQC_DSCP_MAP_LAST   16'h035f

// ****************************************
// Reset values
// ****************************************
`define SQC_RST_STORM_LOW   8'h4a
`define SQC_RST_STORM_HIGH  3'h0
`define SQC_RST_ING_PERIOD  2'h1
`define SQC_RST_TAG_MAP_0   6'h08
`define SQC_RST_TAG_MAP_1   6'h1a
`define SQC_RST_TAG_MAP_2   6'h2c
`define SQC_RST_TAG_MAP_3   6'h3e
`define SQC_RST_DSCP_MAP    6'h00

// ****************************************
// Fields
// ****************************************
`define SQC_BIT_PAUSE_FWD   0
`define SQC_BIT_QUEUE_EGR   3
`define SQC_BIT_RATE_RSVD   6
`define SQC_ING_LO          4
`define SQC_ING_HI          5
`define SQC_BIT_FREEZE      6
`define SQC_BIT_FLUSH       7
`define SQC_BIT_DSCP_EN     0
`define SQC_BIT_DSCP_RSVD   1
`define SQC_STORM_SHIFT     6
`define SQC_SPEED_100       2'h1
`define SQC_SPEED_1000      2'h2

// ****************************************
// Timing
// ****************************************
`define SQC_CLK_KHZ         40000
`define SQC_GIG_MS          5
`define SQC_FAST_MS         50
`define SQC_TEN_MS          500
`define SQC_ING16_MS        16
`define SQC_ING64_MS        64
`define SQC_ING256_MS       256
`define SQC_CYC(ms)         ((ms) * `SQC_CLK_KHZ)

`endif

// File: design/sqc_switch_global_qos_control.v
// Global switch QoS control bank: storm limiting, pause forwarding, rate-limit setup,
// counter flush and freeze, tag and DSCP priority maps.
// Assumes a single 40 MHz clock; frame and port inputs come from logic on that clock.
//
// How it works
// - Storm rate low byte, resets to 0x4A
// - Budget per period is rate times 64
// - Period 5, 50, 500 ms by speed
// - Pause bit one forwards PAUSE frames
// - Bit 3 chooses queue-based egress limiting
// - Flush bit clears counters, then self-clears
// - Freeze bit holds counters while set
// - Eight tag codes map, two per byte
// - Tag map entries reset to own code
// - Remap disabled uses DSCP bits 5:3
// - DSCP map entries reset to zero
// - Storm bits 10:8 in companion byte
// - DSCP table continues two per byte
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "sqc_regs.vh"

module sqc_switch_global_qos_control #(
  parameter       NUM_PORTS  = 5,
  parameter       LEN_W      = 14,
  parameter       CNT_W      = 25,
  parameter       GIG_CYC    = `SQC_CYC(`SQC_GIG_MS),
  parameter       FAST_CYC   = `SQC_CYC(`SQC_FAST_MS),
  parameter       TEN_CYC    = `SQC_CYC(`SQC_TEN_MS),
  parameter       ING16_CYC  = `SQC_CYC(`SQC_ING16_MS),
  parameter       ING64_CYC  = `SQC_CYC(`SQC_ING64_MS),
  parameter       ING256_CYC = `SQC_CYC(`SQC_ING256_MS)
) (
  // Clock, reset, enable
  input  wire                       clk,
  input  wire                       rstn,
  input  wire                       ce,
  // Register port
  input  wire [`SQC_ADDR_W-1:0]     regAddr,
  input  wire [7:0]                 regWdata,
  input  wire                       regWr,
  input  wire                       regRd,
  output wire [7:0]                 regRdata,
  // Broadcast storm check per port
  input  wire [2*NUM_PORTS-1:0]     portSpeed,
  input  wire [NUM_PORTS-1:0]       bcValid,
  input  wire [LEN_W*NUM_PORTS-1:0] bcLen,
  output wire [NUM_PORTS-1:0]       bcDone,
  output wire [NUM_PORTS-1:0]       bcDrop,
  // Switch controls
  output wire                       pauseForward,
  output wire                       queueEgress,
  output wire [1:0]                 ingPeriodSel,
  output wire                       ingPeriodTick,
  output wire                       mibFlush,
  output wire                       mibFreeze,
  // Priority lookup
  input  wire [2:0]                 pcpIn,
  input  wire [5:0]                 dscpIn,
  output wire [2:0]                 tagPrio,
  output wire [2:0]                 ipPrio
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]       stormLow_r;
  reg  [2:0]       stormHigh_r;
  reg              pauseFwd_r;
  reg              rateRsvd_r;
  reg  [1:0]       ingSel_r;
  reg              queueEgr_r;
  reg              flush_r;
  reg              freeze_r;
  reg  [5:0]       tagMap_r [0:3];
  reg              dscpEn_r;
  reg              dscpRsvd_r;
  reg  [5:0]       dscpMap_r [0:31];
  reg  [7:0]       rdata_r;
  reg  [2:0]       tagPrio_r;
  reg  [2:0]       ipPrio_r;
  reg  [7:0]       rdNxt;
  integer          k;

  wire             inDscp = (regAddr >= `SQC_DSCP_MAP_FIRST) && (regAddr <= `SQC_DSCP_MAP_LAST);
  wire [4:0]       dscpIdx = regAddr[4:0];
  wire [5:0]       wrPair = {regWdata[6:4], regWdata[2:0]};

  // Two 3-bit entries per byte, reserved bits 7 and 3 read zero
  function [7:0] pairByte;
    input [5:0] pair;
    begin
      pairByte = {1'b0, pair[5:3], 1'b0, pair[2:0]};
    end
  endfunction

  // Entry for code c: even codes in the low half, odd codes in the high half
  function [2:0] pairPick;
    input [5:0] pair;
    input       odd;
    begin
      pairPick = odd ? pair[5:3] : pair[2:0];
    end
  endfunction

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stormLow_r  <= `SQC_RST_STORM_LOW;
      stormHigh_r <= `SQC_RST_STORM_HIGH;
      pauseFwd_r  <= 1'b0;
      rateRsvd_r  <= 1'b0;
      ingSel_r    <= `SQC_RST_ING_PERIOD;
      queueEgr_r  <= 1'b0;
      flush_r     <= 1'b0;
      freeze_r    <= 1'b0;
      tagMap_r[0] <= `SQC_RST_TAG_MAP_0;
      tagMap_r[1] <= `SQC_RST_TAG_MAP_1;
      tagMap_r[2] <= `SQC_RST_TAG_MAP_2;
      tagMap_r[3] <= `SQC_RST_TAG_MAP_3;
      dscpEn_r    <= 1'b0;
      dscpRsvd_r  <= 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
        dscpMap_r[k] <= `SQC_RST_DSCP_MAP;
      end
    end else if (ce) begin
      // Flush lasts one cycle after the write
      flush_r <= 1'b0;
      if (regWr) begin
        case (regAddr)
          `SQC_STORM_HIGH: begin
            stormHigh_r <= regWdata[2:0];
          end
          `SQC_STORM_LOW: begin
            stormLow_r <= regWdata;
          end
          `SQC_PAUSE_FWD: begin
            pauseFwd_r <= regWdata[`SQC_BIT_PAUSE_FWD];
          end
          `SQC_RATE_CFG: begin
            rateRsvd_r <= regWdata[`SQC_BIT_RATE_RSVD];
            ingSel_r   <= regWdata[`SQC_ING_HI:`SQC_ING_LO];
            queueEgr_r <= regWdata[`SQC_BIT_QUEUE_EGR];
          end
          `SQC_CNT_CTRL: begin
            flush_r  <= regWdata[`SQC_BIT_FLUSH];
            freeze_r <= regWdata[`SQC_BIT_FREEZE];
          end
          `SQC_TAG_MAP_0: begin
            tagMap_r[0] <= wrPair;
          end
          `SQC_TAG_MAP_1: begin
            tagMap_r[1] <= wrPair;
          end
          `SQC_TAG_MAP_2: begin
            tagMap_r[2] <= wrPair;
          end
          `SQC_TAG_MAP_3: begin
            tagMap_r[3] <= wrPair;
          end
          `SQC_DSCP_EN: begin
            dscpEn_r   <= regWdata[`SQC_BIT_DSCP_EN];
            dscpRsvd_r <= regWdata[`SQC_BIT_DSCP_RSVD];
          end
          default: begin
            if (inDscp) begin
              dscpMap_r[dscpIdx] <= wrPair;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    rdNxt = 8'h00;
    case (regAddr)
      `SQC_STORM_HIGH: rdNxt = {5'h00, stormHigh_r};
      `SQC_STORM_LOW:  rdNxt = stormLow_r;
      `SQC_PAUSE_FWD:  rdNxt = {7'h00, pauseFwd_r};
      `SQC_RATE_CFG:   rdNxt = {1'b0, rateRsvd_r, ingSel_r, queueEgr_r, 3'h0};
      `SQC_CNT_CTRL:   rdNxt = {flush_r, freeze_r, 6'h00};
      `SQC_TAG_MAP_0:  rdNxt = pairByte(tagMap_r[0]);
      `SQC_TAG_MAP_1:  rdNxt = pairByte(tagMap_r[1]);
      `SQC_TAG_MAP_2:  rdNxt = pairByte(tagMap_r[2]);
      `SQC_TAG_MAP_3:  rdNxt = pairByte(tagMap_r[3]);
      `SQC_DSCP_EN:    rdNxt = {6'h00, dscpRsvd_r, dscpEn_r};
      default: begin
        if (inDscp) begin
          rdNxt = pairByte(dscpMap_r[dscpIdx]);
        end
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (ce) begin
      rdata_r <= regRd ? rdNxt : 8'h00;
    end
  end

  // ****************************************
  // Priority lookup
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tagPrio_r <= 3'h0;
      ipPrio_r  <= 3'h0;
    end else if (ce) begin
      tagPrio_r <= pairPick(tagMap_r[pcpIn[2:1]], pcpIn[0]);
      if (dscpEn_r) begin
        ipPrio_r <= pairPick(dscpMap_r[dscpIn[5:1]], dscpIn[0]);
      end else begin
        ipPrio_r <= dscpIn[5:3];
      end
    end
  end

  // ****************************************
  // Period timers
  // ****************************************
  localparam integer     GIG_END     = GIG_CYC - 1;
  localparam integer     FAST_END    = FAST_CYC - 1;
  localparam integer     TEN_END     = TEN_CYC - 1;
  localparam integer     ING16_END   = ING16_CYC - 1;
  localparam integer     ING64_END   = ING64_CYC - 1;
  localparam integer     ING256_END  = ING256_CYC - 1;
  // Terminal counts cut to the counter width on purpose
  localparam [CNT_W-1:0] GIG_LAST    = GIG_END[CNT_W-1:0];
  localparam [CNT_W-1:0] FAST_LAST   = FAST_END[CNT_W-1:0];
  localparam [CNT_W-1:0] TEN_LAST    = TEN_END[CNT_W-1:0];
  localparam [CNT_W-1:0] ING16_LAST  = ING16_END[CNT_W-1:0];
  localparam [CNT_W-1:0] ING64_LAST  = ING64_END[CNT_W-1:0];
  localparam [CNT_W-1:0] ING256_LAST = ING256_END[CNT_W-1:0];

  reg  [CNT_W-1:0] gigCnt_r;
  reg  [CNT_W-1:0] fastCnt_r;
  reg  [CNT_W-1:0] tenCnt_r;
  reg  [CNT_W-1:0] ingCnt_r;
  reg  [CNT_W-1:0] ingLast;
  wire             gigTick  = (gigCnt_r == GIG_LAST);
  wire             fastTick = (fastCnt_r == FAST_LAST);
  wire             tenTick  = (tenCnt_r == TEN_LAST);
  wire             ingTick  = (ingCnt_r >= ingLast);

  // Wrapping counter step
  function [CNT_W-1:0] stepCnt;
    input [CNT_W-1:0] cnt;
    input             wrap;
    begin
      stepCnt = wrap ? {CNT_W{1'b0}} : cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  always @* begin
    if (ingSel_r[1]) begin
      ingLast = ING256_LAST;
    end else if (ingSel_r[0]) begin
      ingLast = ING64_LAST;
    end else begin
      ingLast = ING16_LAST;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gigCnt_r  <= {CNT_W{1'b0}};
      fastCnt_r <= {CNT_W{1'b0}};
      tenCnt_r  <= {CNT_W{1'b0}};
      ingCnt_r  <= {CNT_W{1'b0}};
    end else if (ce) begin
      gigCnt_r  <= stepCnt(gigCnt_r, gigTick);
      fastCnt_r <= stepCnt(fastCnt_r, fastTick);
      tenCnt_r  <= stepCnt(tenCnt_r, tenTick);
      ingCnt_r  <= stepCnt(ingCnt_r, ingTick);
    end
  end

  // ****************************************
  // Broadcast storm limiter
  // ****************************************
  localparam BUD_W = 11 + `SQC_STORM_SHIFT;

  wire [BUD_W-1:0] budget = {stormHigh_r, stormLow_r, {`SQC_STORM_SHIFT{1'b0}}};

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : gPort
      reg  [BUD_W:0]   used_r;
      reg              done_r;
      reg              drop_r;
      reg              tick;
      wire [1:0]       spd  = portSpeed[2*p +: 2];
      wire [BUD_W:0]   base = tick ? {(BUD_W+1){1'b0}} : used_r;
      wire [BUD_W:0]   sum  = base + {{(BUD_W+1-LEN_W){1'b0}}, bcLen[LEN_W*p +: LEN_W]};
      wire             over = (sum > {1'b0, budget});

      always @* begin
        if (spd == `SQC_SPEED_1000) begin
          tick = gigTick;
        end else if (spd == `SQC_SPEED_100) begin
          tick = fastTick;
        end else begin
          tick = tenTick;
        end
      end

      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          used_r <= {(BUD_W+1){1'b0}};
          done_r <= 1'b0;
          drop_r <= 1'b0;
        end else if (ce) begin
          done_r <= bcValid[p];
          if (bcValid[p]) begin
            drop_r <= over;
            used_r <= over ? base : sum;
          end else begin
            drop_r <= 1'b0;
            used_r <= base;
          end
        end
      end

      assign bcDone[p] = done_r;
      assign bcDrop[p] = drop_r;
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdata      = rdata_r;
  assign pauseForward  = pauseFwd_r;
  assign queueEgress   = queueEgr_r;
  assign ingPeriodSel  = ingSel_r;
  assign ingPeriodTick = ingTick & ce;
  assign mibFlush      = flush_r;
  assign mibFreeze     = freeze_r;
  assign tagPrio       = tagPrio_r;
  assign ipPrio        = ipPrio_r;

endmodule // sqc_switch_global_qos_control

// File: testbench/sqc_ctl_sva.sv
// Assertions on the QoS control bank, watching its top-level ports only.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "sqc_regs.vh"
module sqc_ctl_sva #(parameter NUM_PORTS = 5) (
  // Clock, reset, enable
  input wire                   clk,
  input wire                   rstn,
  input wire                   ce,
  // Register port
  input wire [`SQC_ADDR_W-1:0] regAddr,
  input wire [7:0]             regWdata,
  input wire                   regWr,
  input wire                   regRd,
  input wire [7:0]             regRdata,
  // Storm check, controls, lookup
  input wire [NUM_PORTS-1:0]   bcValid,
  input wire [NUM_PORTS-1:0]   bcDone,
  input wire [NUM_PORTS-1:0]   bcDrop,
  input wire                   pauseForward,
  input wire                   queueEgress,
  input wire [1:0]             ingPeriodSel,
  input wire                   mibFlush,
  input wire                   mibFreeze,
  input wire [5:0]             dscpIn,
  input wire [2:0]             ipPrio
);
  // ****
  // Remap enable shadow
  // ****
  reg dscpEn_r;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      dscpEn_r <= 1'b0;
    else if (ce && regWr && regAddr == `SQC_DSCP_EN)
      dscpEn_r <= regWdata[0];
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_rsvd;
    ce && regRd && regAddr == `SQC_PAUSE_FWD |=> regRdata[7:1] == 7'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_pause;
    ce && regWr && regAddr == `SQC_PAUSE_FWD |=> pauseForward == $past(regWdata[0]);
  endproperty
  a_pause: assert property (p_pause) else $error("pause forward wrong");
  property p_egr;
    ce && regWr && regAddr == `SQC_RATE_CFG |=> queueEgress == $past(regWdata[3]);
  endproperty
  a_egr: assert property (p_egr) else $error("egress mode wrong");
  property p_ing;
    ce && regWr && regAddr == `SQC_RATE_CFG |=> ingPeriodSel == $past(regWdata[5:4]);
  endproperty
  a_ing: assert property (p_ing) else $error("ingress period select wrong");
  property p_flush;
    ce && regWr && regAddr == `SQC_CNT_CTRL && regWdata[7] |=> mibFlush ##1 !mibFlush;
  endproperty
  a_flush: assert property (p_flush) else $error("flush pulse wrong");
  property p_freeze;
    ce && regWr && regAddr == `SQC_CNT_CTRL |=> mibFreeze == $past(regWdata[6]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze level wrong");
  property p_done;
    $past(ce) && $past(rstn) |-> bcDone == $past(bcValid);
  endproperty
  a_done: assert property (p_done) else $error("storm answer missing");
  property p_ip;
    $past(ce) && $past(rstn) && !$past(dscpEn_r) |-> ipPrio == $past(dscpIn[5:3]);
  endproperty
  a_ip: assert property (p_ip) else $error("direct priority wrong");
  c_flush: cover property (mibFlush);
  c_drop: cover property (|bcDrop);
  c_read: cover property (ce && regRd);
endmodule // sqc_ctl_sva

bind sqc_switch_global_qos_control sqc_ctl_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (
  .clk, .rstn, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .bcValid, .bcDone,
  .bcDrop, .pauseForward, .queueEgress, .ingPeriodSel, .mibFlush, .mibFreeze, .dscpIn, .ipPrio
);

// File: testbench/sqc_switch_global_qos_control_tb_top.sv
// Self-checking bench for the QoS control bank.
// Assumes the checker is bound in and periods are shortened by parameters.
`timescale 1ns/1ps
module sqc_switch_global_qos_control_tb_top;
  reg         clk, rstn, ce, regWr, regRd;
  reg  [15:0] regAddr;
  reg  [7:0]  regWdata, sh [0:127];
  reg  [9:0]  portSpeed;
  reg  [4:0]  bcValid;
  reg  [69:0] bcLen;
  reg  [2:0]  pcpIn;
  reg  [5:0]  dscpIn;
  reg  [31:0] rv;
  wire [7:0]  regRdata;
  wire [4:0]  bcDone, bcDrop;
  wire [2:0]  tagPrio, ipPrio;
  wire [1:0]  ingPeriodSel;
  wire        pauseForward, queueEgress, ingPeriodTick, mibFlush, mibFreeze;
  integer     seed, error_cnt, cmp_count, i, k, n, pass [0:4];

  sqc_switch_global_qos_control #(.GIG_CYC(20), .FAST_CYC(200), .TEN_CYC(2000),
    .ING16_CYC(40), .ING64_CYC(80), .ING256_CYC(160)) uut (.clk, .rstn, .ce, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .portSpeed, .bcValid, .bcLen, .bcDone, .bcDrop,
    .pauseForward, .queueEgress, .ingPeriodSel, .ingPeriodTick, .mibFlush, .mibFreeze,
    .pcpIn, .dscpIn, .tagPrio, .ipPrio);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ****
  // Checks and bus tasks
  // ****
  task summarize;
    begin
      if (error_cnt == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task rng(input integer v, input integer lo, input integer hi);
    chk({7'h0, v >= lo && v <= hi}, 8'h01);
  endtask
  // Bits of each address that hold a written value; all others read zero
  function [7:0] msk(input [15:0] a);
    case (a)
      16'h0332: msk = 8'h07;
      16'h0333: msk = 8'hff;
      16'h0334: msk = 8'h01;
      16'h0335: msk = 8'h78;
      16'h0336: msk = 8'h40;
      16'h0338, 16'h0339, 16'h033a, 16'h033b: msk = 8'h77;
      16'h033e: msk = 8'h03;
      default: msk = (a >= 16'h0340 && a <= 16'h035f) ? 8'h77 : 8'h00;
    endcase
  endfunction
  function [7:0] pick(input [7:0] b, input odd);
    pick = {5'h0, odd ? b[6:4] : b[2:0]};
  endfunction
  task wr(input [15:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
      if (ce)
        sh[a[6:0]] = d & msk(a);
    end
  endtask
  task rd(input [15:0] a);
    begin
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(regRdata, sh[a[6:0]]);
    end
  endtask
  task sweep;
    for (i = 'h330; i < 'h370; i = i + 1)
      rd(i[15:0]);
  endtask
  task lookup;
    for (k = 0; k < 24; k = k + 1) begin
      rv = $random(seed);
      @(posedge clk);
      pcpIn <= k[2:0];
      dscpIn <= rv[5:0];
      repeat (2) @(posedge clk);
      #1 chk({5'h0, tagPrio}, pick(sh['h38 + k[2:1]], k[0]));
      n = sh['h3e][0] ? pick(sh['h40 + rv[5:1]], rv[0]) : {5'h0, rv[5:3]};
      chk({5'h0, ipPrio}, n[7:0]);
    end
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 18;
    error_cnt = 0;
    cmp_count = 0;
    {rstn, regWr, regRd, regAddr, regWdata, pcpIn, dscpIn} = 0;
    {portSpeed, bcValid, bcLen} = 0;
    ce = 1'b1;
    for (i = 0; i < 128; i = i + 1)
      sh[i] = 8'h00;
    sh['h33] = 8'h4a;
    sh['h35] = 8'h10;
    for (i = 0; i < 4; i = i + 1)
      sh['h38 + i] = 8'h10 + 8'h22 * i[7:0];
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    sweep;
    lookup;
    for (k = 0; k < 80; k = k + 1) begin
      rv = $random(seed);
      wr(16'h0330 + {10'h0, rv[13:8]}, rv[7:0]);
    end
    sweep;
    wr(16'h033e, 8'h01);
    lookup;
    wr(16'h0336, 8'hc0);
    rd(16'h0336);
    chk({7'h0, mibFreeze}, 8'h01);
    @(posedge clk);
    ce <= 1'b0;
    wr(16'h0334, ~sh['h34]);
    ce <= 1'b1;
    rd(16'h0334);
    wr(16'h0332, 8'h00);
    wr(16'h0333, 8'h02);
    @(posedge clk);
    rv = $random(seed);
    // Ports 2 and 3 draw either 10 Mb/s code; lengths keep two or one frame per period
    portSpeed <= {2'h2, {2{rv[22]}}, {2{rv[23]}}, 2'h1, 2'h2};
    bcLen <= {8'h01, rv[21:16] | 6'h01, 10'h003, rv[15:12], 10'h003, rv[11:8],
              10'h003, rv[7:4], 10'h003, rv[3:0]};
    bcValid <= 5'h1f;
    for (i = 0; i < 5; i = i + 1)
      pass[i] = 0;
    repeat (600) begin
      @(posedge clk);
      #1 for (i = 0; i < 5; i = i + 1)
        pass[i] = pass[i] + (bcDone[i] && !bcDrop[i]);
    end
    @(posedge clk);
    bcValid <= 5'h00;
    rng(pass[0], 60, 62);
    rng(pass[4], 30, 31);
    rng(pass[1], 6, 8);
    rng(pass[2], 2, 4);
    rng(pass[3], 2, 4);
    for (k = 0; k < 4; k = k + 1) begin
      wr(16'h0335, {2'h0, k[1:0], 4'h0});
      n = 0;
      repeat (480) begin
        @(posedge clk);
        #1 n = n + ingPeriodTick;
      end
      i = k == 0 ? 12 : k == 1 ? 6 : 3;
      rng(n, i - 1, i + 1);
    end
    summarize;
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt = error_cnt + 1;
    summarize;
  end
endmodule // sqc_switch_global_qos_control_tb_top
